// ==== hw/eps_pkg.sv ====
// Package: constants and types for the EPROM programming sequencer
package eps_pkg;
	// ==========================================
	// Geometry
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int FIFO_DEPTH = 4;
	localparam logic [ADDR_W-1:0] FIRST_ADDR = 16'h0000;
	localparam logic [ADDR_W-1:0] ID_CODE_SEL_ADDR = 16'h0001;
	// ==========================================
	// Timing, figures as printed
	localparam int CLK_PERIOD_PS = 5000;
	localparam int PULSE_NOM_NS = 100000;
	localparam int SETUP_MIN_NS = 2000;
	localparam int VERIFY_OE_MAX_NS = 150;
	localparam int FLOAT_MAX_NS = 130;
	localparam int PULSE_CYC = (PULSE_NOM_NS * 1000) / CLK_PERIOD_PS;
	localparam int SETUP_CYC = (SETUP_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int VERIFY_CYC = (VERIFY_OE_MAX_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int FLOAT_CYC = (FLOAT_MAX_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SYNC_CYC = 3;
	localparam int CNT_W = 16;
	localparam logic [3:0] MAX_RETRY = 4'ha;
	// ==========================================
	// Sequencer states
	typedef enum logic [3:0] {
		ST_IDLE    = 4'h0,
		ST_PWR_VCC = 4'h1,
		ST_PWR_VPP = 4'h3,
		ST_LOAD    = 4'h2,
		ST_PULSE   = 4'h6,
		ST_HOLD    = 4'h7,
		ST_VFY     = 4'h5,
		ST_FLOAT   = 4'h4,
		ST_PWR_DN  = 4'hc,
		ST_READ    = 4'hd,
		ST_READ_FL = 4'hf,
		ST_DONE    = 4'he,
		ST_ID      = 4'h8
	} eps_state_type;
endpackage : eps_pkg

// ==== hw/eps_fifo.sv ====
// Small synchronous FIFO used on the source data path
`timescale 1ns/100ps
`default_nettype none
module eps_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input  wire logic             clock_in,
	input  wire logic             rst_b_in,
	// Fill side
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	// Drain side
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic [WIDTH-1:0]      out_data_out
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW:0]      wr_ptr;
	logic [PW:0]      rd_ptr;
	wire              do_wr = in_valid_in && in_ready_out;
	wire              do_rd = out_valid_out && out_ready_in;
	assign in_ready_out  = (wr_ptr - rd_ptr) != (PW+1)'(DEPTH);
	assign out_valid_out = wr_ptr != rd_ptr;
	assign out_data_out  = mem[rd_ptr[PW-1:0]];
	always_ff @(posedge clock_in) begin
		if (do_wr) begin
			mem[wr_ptr[PW-1:0]] <= in_data_in;
		end
	end
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			wr_ptr <= wr_ptr + (PW+1)'(do_wr);
			rd_ptr <= rd_ptr + (PW+1)'(do_rd);
		end
	end
endmodule // eps_fifo
`default_nettype wire

// ==== hw/eps_sequencer.sv ====
// Programmer that drives a 16-bit one-time EPROM through its pins
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Program strobe low for 100 us nominal, within 95 to 105 us.
// - Start at first address, raise core supply 6.5 V, then program supply 13 V.
// - First pass: one program pulse per address, no verify.
// - Second pass verifies each word; mismatches get up to ten pulses, verifying each.
// - Word still failing after ten pulses ends programming with device failed.
// - Verified word advances to next address until all are checked.
// - Lower both supplies to 5 V, read all words back, compare, report.
// - Identification needs the select address line at the raised 12 V level.
// - Output enable may lag chip enable by access time difference.
// - Verify samples up to 150 ns after output enable; allow 130 ns float.
// - Core supply on no later, off no earlier, than programming supply.
// - Identification holds other address lines low, code select picks word.
module eps_sequencer
	import eps_pkg::*;
(
	// Clock and reset
	input  wire logic                      clock_in,
	input  wire logic                      rst_b_in,
	// Commands
	input  wire logic                      start_prog_in,
	input  wire logic                      start_id_in,
	input  wire logic                      id_word_sel_in,
	input  wire logic [eps_pkg::ADDR_W-1:0] last_addr_in,
	// Source data, one word per address, sent once per pass
	input  wire logic                      src_valid_in,
	output logic                           src_ready_out,
	input  wire logic [eps_pkg::DATA_W-1:0] src_data_in,
	// Status
	output logic                           busy_out,
	output logic                           done_out,
	output logic                           pass_out,
	output logic                           fail_out,
	output logic [eps_pkg::DATA_W-1:0]     id_word_out,
	output logic [eps_pkg::ADDR_W-1:0]     fail_addr_out,
	// Device pins
	output logic [eps_pkg::ADDR_W-1:0]     addr_out,
	output logic                           chip_enable_n_out,
	output logic                           output_enable_n_out,
	output logic                           program_strobe_n_out,
	output logic                           vcc_prog_level_out,
	output logic                           vpp_prog_level_out,
	output logic                           id_select_raise_out,
	input  wire logic [eps_pkg::DATA_W-1:0] data_in,
	output logic [eps_pkg::DATA_W-1:0]     data_out,
	output logic                           data_oe_out
);
	import eps_pkg::*;
	// ==========================================
	// Pin synchroniser
	logic [DATA_W-1:0] data_meta;
	logic [DATA_W-1:0] data_sync;
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			data_meta <= '0;
			data_sync <= '0;
		end else begin
			data_meta <= data_in;
			data_sync <= data_meta;
		end
	end
	// ==========================================
	// Source FIFO
	logic              fifo_valid;
	logic              fifo_ready;
	logic [DATA_W-1:0] fifo_data;
	eps_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clock_in      (clock_in),
		.rst_b_in      (rst_b_in),
		.in_valid_in   (src_valid_in),
		.in_ready_out  (src_ready_out),
		.in_data_in    (src_data_in),
		.out_valid_out (fifo_valid),
		.out_ready_in  (fifo_ready),
		.out_data_out  (fifo_data)
	);
	// ==========================================
	// Sequencer
	eps_state_type     state;
	eps_state_type     next_state;
	logic [CNT_W-1:0]  cnt;
	logic [3:0]        retry;
	logic [1:0]        pass_no;
	logic [DATA_W-1:0] wdata;
	logic              have_word;
	logic              ok;
	// Pass 0 programs, pass 1 verifies, pass 2 reads back at 5 V
	wire               cnt_done  = cnt == '0;
	wire               last_addr = addr_out == last_addr_in;
	wire               match     = data_sync == wdata;
	wire               verify_pass = pass_no == 2'h1;
	wire               retry_left = retry != MAX_RETRY;
	assign fifo_ready = (state == ST_LOAD) && !have_word;
	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (start_prog_in) begin
					next_state = ST_PWR_VCC;
				end else if (start_id_in) begin
					next_state = ST_ID;
				end
			end
			ST_PWR_VCC: if (cnt_done) next_state = ST_PWR_VPP;
			ST_PWR_VPP: if (cnt_done) next_state = ST_LOAD;
			ST_LOAD: begin
				if (have_word && cnt_done) begin
					next_state = (pass_no == 2'h0 || !ok) ? ST_PULSE : ST_VFY;
				end
			end
			ST_PULSE: if (cnt_done) next_state = ST_HOLD;
			ST_HOLD: if (cnt_done) next_state = (pass_no == 2'h0) ? ST_FLOAT : ST_VFY;
			ST_VFY: if (cnt_done) next_state = ST_FLOAT;
			ST_FLOAT: begin
				if (cnt_done) begin
					if (verify_pass && !ok && !retry_left) begin
						next_state = ST_PWR_DN;
					end else if (verify_pass && !ok) begin
						// Retry goes back through load so data and enables get full setup
						next_state = ST_LOAD;
					end else if (!last_addr) begin
						next_state = ST_LOAD;
					end else if (pass_no == 2'h2) begin
						next_state = ST_DONE;
					end else if (pass_no == 2'h1) begin
						next_state = ST_PWR_DN;
					end else begin
						next_state = ST_LOAD;
					end
				end
			end
			ST_PWR_DN: if (cnt_done) next_state = fail_out ? ST_DONE : ST_LOAD;
			ST_ID: if (cnt_done) next_state = ST_READ_FL;
			ST_READ_FL: if (cnt_done) next_state = ST_DONE;
			ST_DONE: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end
	// Count reloads on every state change
	logic [CNT_W-1:0] next_cnt;
	always_comb begin
		next_cnt = cnt_done ? cnt : cnt - 1'b1;
		if (next_state != state) begin
			unique case (next_state)
				ST_PULSE: next_cnt = CNT_W'(PULSE_CYC - 1);
				ST_VFY:   next_cnt = CNT_W'(VERIFY_CYC + SYNC_CYC - 1);
				ST_ID:    next_cnt = CNT_W'(SETUP_CYC + VERIFY_CYC + SYNC_CYC - 1);
				ST_FLOAT,
				ST_READ_FL: next_cnt = CNT_W'(FLOAT_CYC - 1);
				default:  next_cnt = CNT_W'(SETUP_CYC - 1);
			endcase
		end
		// Setup counts from the word reaching the pins, not from entering load
		if (state == ST_LOAD && !have_word) begin
			next_cnt = CNT_W'(SETUP_CYC - 1);
		end
	end
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state <= ST_IDLE;
			cnt   <= '0;
		end else begin
			state <= next_state;
			cnt   <= next_cnt;
		end
	end
	// Datapath
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			addr_out      <= '0;
			wdata         <= '0;
			have_word     <= 1'b0;
			retry         <= '0;
			pass_no       <= '0;
			ok            <= 1'b0;
			pass_out      <= 1'b0;
			fail_out      <= 1'b0;
			fail_addr_out <= '0;
			id_word_out   <= '0;
			vcc_prog_level_out  <= 1'b0;
			vpp_prog_level_out  <= 1'b0;
			id_select_raise_out <= 1'b0;
		end else begin
			if (state == ST_IDLE && start_prog_in) begin
				addr_out <= FIRST_ADDR;
				pass_no  <= 2'h0;
				pass_out <= 1'b0;
				fail_out <= 1'b0;
				retry    <= '0;
				vcc_prog_level_out <= 1'b1;
			end
			if (state == ST_IDLE && start_id_in) begin
				addr_out <= id_word_sel_in ? ID_CODE_SEL_ADDR : FIRST_ADDR;
				id_select_raise_out <= 1'b1;
			end
			if (state == ST_PWR_VCC && cnt_done) begin
				vpp_prog_level_out <= 1'b1;
			end
			if (fifo_ready && fifo_valid) begin
				wdata     <= fifo_data;
				have_word <= 1'b1;
			end
			if (state == ST_HOLD && cnt_done && verify_pass) begin
				retry <= retry + 4'h1;
			end
			if (state == ST_VFY && cnt_done) begin
				ok <= match;
			end
			if (state == ST_FLOAT && cnt_done) begin
				if (verify_pass && !ok && !retry_left) begin
					fail_out      <= 1'b1;
					fail_addr_out <= addr_out;
					vpp_prog_level_out <= 1'b0;
				end else if (ok || !verify_pass) begin
					have_word <= 1'b0;
					retry     <= '0;
					ok        <= 1'b1;
					if (last_addr) begin
						addr_out <= FIRST_ADDR;
						pass_no  <= pass_no + 2'h1;
						if (pass_no == 2'h1) begin
							vpp_prog_level_out <= 1'b0;
						end
						if (pass_no == 2'h2) begin
							pass_out <= !fail_out && ok;
						end
					end else begin
						addr_out <= addr_out + 1'b1;
					end
				end
				if (pass_no == 2'h2 && !ok) begin
					fail_out      <= 1'b1;
					fail_addr_out <= addr_out;
				end
			end
			if (state == ST_PWR_DN && cnt_done) begin
				vcc_prog_level_out <= 1'b0;
				if (fail_out) begin
					have_word <= 1'b0;
				end
			end
			if (state == ST_ID && cnt_done) begin
				id_word_out <= data_sync;
			end
			if (state == ST_READ_FL && cnt_done) begin
				id_select_raise_out <= 1'b0;
				addr_out <= FIRST_ADDR;
			end
		end
	end
	// ==========================================
	// Pin levels
	wire pulsing = state == ST_PULSE;
	wire reading = state == ST_VFY || state == ST_ID;
	wire ce_setup = state == ST_LOAD || state == ST_FLOAT;
	// Chip enable settles before the strobe and leads output enable, except in identification where both switch in the same cycle
	assign chip_enable_n_out    = !(pulsing || reading || ce_setup || state == ST_HOLD);
	assign output_enable_n_out  = !reading;
	assign program_strobe_n_out = !pulsing;
	// Drivers stay on through setup and hold, off once output enable falls
	assign data_oe_out = (state == ST_LOAD && have_word) || pulsing || state == ST_HOLD;
	assign data_out    = wdata;
	assign busy_out    = state != ST_IDLE;
	assign done_out    = state == ST_DONE;
	// ==========================================
	// Checks
	property p_pulse_width;
		@(posedge clock_in) disable iff (!rst_b_in)
		$fell(program_strobe_n_out) |-> !program_strobe_n_out [*8] ##0 (cnt > CNT_W'(PULSE_CYC - 20));
	endproperty
	a_pulse_width: assert property (p_pulse_width) else $error("strobe pulse short");
	// Helper count of strobe-low cycles, judged against the window when the strobe rises
	logic [CNT_W-1:0] strobe_low_cnt;
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			strobe_low_cnt <= '0;
		end else begin
			strobe_low_cnt <= pulsing ? strobe_low_cnt + 1'b1 : '0;
		end
	end
	property p_pulse_window;
		@(posedge clock_in) disable iff (!rst_b_in)
		$rose(program_strobe_n_out) |-> strobe_low_cnt >= CNT_W'(PULSE_CYC - PULSE_CYC / 20)
			&& strobe_low_cnt <= CNT_W'(PULSE_CYC + PULSE_CYC / 20);
	endproperty
	a_pulse_window: assert property (p_pulse_window) else $error("strobe pulse out of window");
	property p_no_drive_while_read;
		@(posedge clock_in) disable iff (!rst_b_in)
		!output_enable_n_out |-> !data_oe_out;
	endproperty
	a_no_drive_while_read: assert property (p_no_drive_while_read) else $error("bus fight");
	property p_vpp_needs_vcc;
		@(posedge clock_in) disable iff (!rst_b_in)
		vpp_prog_level_out |-> vcc_prog_level_out;
	endproperty
	a_vpp_needs_vcc: assert property (p_vpp_needs_vcc) else $error("supply order");
	property p_stable_in_pulse;
		@(posedge clock_in) disable iff (!rst_b_in)
		!program_strobe_n_out && $past(!program_strobe_n_out) |-> $stable(addr_out) && $stable(data_out);
	endproperty
	a_stable_in_pulse: assert property (p_stable_in_pulse) else $error("moved in pulse");
	property p_prog_pins;
		@(posedge clock_in) disable iff (!rst_b_in)
		!program_strobe_n_out |-> !chip_enable_n_out && output_enable_n_out && vpp_prog_level_out;
	endproperty
	a_prog_pins: assert property (p_prog_pins) else $error("bad program pins");
	property p_retry_cap;
		@(posedge clock_in) disable iff (!rst_b_in)
		retry <= MAX_RETRY;
	endproperty
	a_retry_cap: assert property (p_retry_cap) else $error("too many pulses");
	property p_fail_ends;
		@(posedge clock_in) disable iff (!rst_b_in)
		$rose(fail_out) && verify_pass |-> ##[1:500] (state == ST_DONE);
	endproperty
	a_fail_ends: assert property (p_fail_ends) else $error("fail not ended");
	property p_first_pass_no_verify;
		@(posedge clock_in) disable iff (!rst_b_in)
		pass_no == 2'h0 |-> output_enable_n_out || state == ST_ID;
	endproperty
	a_first_pass_no_verify: assert property (p_first_pass_no_verify) else $error("verified");
endmodule // eps_sequencer
`default_nettype wire

// ==== verification/eps_eprom_model.sv ====
// Behavioural one-time EPROM answering the sequencer at its pins
`timescale 1ns/100ps
`default_nettype none
module eps_eprom_model
	import eps_pkg::*;
#(
	parameter logic [15:0] MAKER_WORD  = 16'h005a, // Arbitrary value
	parameter logic [15:0] DEVICE_WORD = 16'h00c3, // Arbitrary value
	parameter int          NEED0       = 2
) (
	// Device pins
	input  wire logic [eps_pkg::ADDR_W-1:0] addr_in,
	input  wire logic                       chip_enable_n_in,
	input  wire logic                       output_enable_n_in,
	input  wire logic                       program_strobe_n_in,
	input  wire logic                       vcc_prog_level_in,
	input  wire logic                       vpp_prog_level_in,
	input  wire logic                       id_select_raise_in,
	input  wire logic [eps_pkg::DATA_W-1:0] data_in,
	input  wire logic                       data_oe_in,
	output logic [eps_pkg::DATA_W-1:0]      dq_out
);
	// ==========================================
	// Array and bookkeeping
	logic [15:0] mem [0:3];
	int          pulses [0:3];
	int          n_err;
	logic [15:0] first_addr;
	logic [15:0] p_addr;
	logic [15:0] p_data;
	logic        armed;
	logic        seen;
	realtime     t0;
	wire         out_on = !chip_enable_n_in && !output_enable_n_in;
	wire  [15:0] code = addr_in[0] ? DEVICE_WORD : MAKER_WORD;
	wire  [15:0] word = id_select_raise_in ? code : mem[addr_in[1:0]];
	initial begin
		for (int i = 0; i < 4; i++) begin
			mem[i] = 16'hffff;
			pulses[i] = 0;
		end
		n_err = 0;
		t0 = 0.0;
		{armed, seen, p_addr, p_data, first_addr} = '0;
		dq_out = 16'h0000;
	end
	// ==========================================
	// Read path: slow to drive, inverted garbage once floated
	always @(addr_in, out_on, word) begin
		if (out_on)
			dq_out <= #45 word;
		else
			dq_out <= #20 ~word;
	end
	// ==========================================
	// Program pulses
	always @(negedge program_strobe_n_in) begin
		if (chip_enable_n_in || !output_enable_n_in || !vpp_prog_level_in || !data_oe_in)
			n_err++;
		t0 = $realtime;
		p_addr = addr_in;
		p_data = data_in;
		armed = 1'b1;
		if (!seen)
			first_addr = addr_in;
		seen = 1'b1;
	end
	always @(posedge program_strobe_n_in) begin
		if (armed) begin
			if ($realtime - t0 < 95000.0 || $realtime - t0 > 105000.0)
				n_err++;
			if (addr_in !== p_addr || data_in !== p_data)
				n_err++;
			pulses[p_addr[1:0]]++;
			// Word zero needs extra pulses so the reprogram loop is exercised
			if (p_addr != 16'h0000 || pulses[0] >= NEED0)
				mem[p_addr[1:0]] = mem[p_addr[1:0]] & p_data;
		end
		armed = 1'b0;
	end
	// ==========================================
	// Sequencing hazards, checked after zero-time settling
	always @(data_oe_in, out_on) #1 if (data_oe_in === 1'b1 && out_on) n_err++;
	always @(vcc_prog_level_in, vpp_prog_level_in) #1
		if (vpp_prog_level_in === 1'b1 && vcc_prog_level_in !== 1'b1) n_err++;
	always @(id_select_raise_in, addr_in) #1
		if (id_select_raise_in === 1'b1 && addr_in[15:1] != 15'h0000) n_err++;
endmodule // eps_eprom_model
`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench for the EPROM programming sequencer
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import eps_pkg::*;
	localparam logic [15:0] MAKER_WORD  = 16'h005a; // Arbitrary value
	localparam logic [15:0] DEVICE_WORD = 16'h00c3; // Arbitrary value
	// ==========================================
	// Signals
	logic        clock_in;
	logic        rst_b_in;
	logic        start_prog;
	logic        start_id;
	logic        id_sel;
	logic        src_valid;
	logic [15:0] src_data;
	logic [15:0] last_addr;
	logic [15:0] w [0:1];
	wire         src_ready, busy, done, pass, fail, ce_n, oe_n, strobe_n, vcc, vpp, raise, d_oe;
	wire  [15:0] id_word, fail_addr, addr, dq, d_out;
	int          n_fail;
	int          num_checks;
	eps_sequencer dut_u (.clock_in(clock_in), .rst_b_in(rst_b_in), .start_prog_in(start_prog),
		.start_id_in(start_id), .id_word_sel_in(id_sel), .last_addr_in(last_addr),
		.src_valid_in(src_valid), .src_ready_out(src_ready), .src_data_in(src_data),
		.busy_out(busy), .done_out(done), .pass_out(pass), .fail_out(fail),
		.id_word_out(id_word), .fail_addr_out(fail_addr), .addr_out(addr),
		.chip_enable_n_out(ce_n), .output_enable_n_out(oe_n), .program_strobe_n_out(strobe_n),
		.vcc_prog_level_out(vcc), .vpp_prog_level_out(vpp), .id_select_raise_out(raise),
		.data_in(dq), .data_out(d_out), .data_oe_out(d_oe));
	eps_eprom_model #(.MAKER_WORD(MAKER_WORD), .DEVICE_WORD(DEVICE_WORD), .NEED0(2)) model_u (
		.addr_in(addr), .chip_enable_n_in(ce_n), .output_enable_n_in(oe_n),
		.program_strobe_n_in(strobe_n), .vcc_prog_level_in(vcc), .vpp_prog_level_in(vpp),
		.id_select_raise_in(raise), .data_in(d_out), .data_oe_in(d_oe), .dq_out(dq));
	// ==========================================
	// Shared tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic push(input logic [15:0] d);
		int n;
		@(negedge clock_in);
		src_valid = 1'b1;
		src_data = d;
		for (n = 0; src_ready !== 1'b1 && n < 60000; n++) @(negedge clock_in);
		check(16'(src_ready), 16'h0001);
		@(posedge clock_in);
		@(negedge clock_in);
		src_valid = 1'b0;
		src_data = ~d;
	endtask
	task automatic wait_done(input int lim);
		int n;
		for (n = 0; done !== 1'b1 && n < lim; n++) @(negedge clock_in);
		check(16'(done), 16'h0001);
	endtask
	// ==========================================
	// Scenarios
	task automatic t_prog;
		@(negedge clock_in);
		last_addr = 16'h0001;
		start_prog = 1'b1;
		@(negedge clock_in);
		start_prog = 1'b0;
		check(16'(busy), 16'h0001);
		check(16'({vcc, vpp}), 16'h0002);
		for (int i = 0; i < 4; i++) push(w[i % 2]);
		// Supplies still ramping, nothing drains yet, so the buffer must refuse
		check(16'(src_ready), 16'h0000);
		start_id = 1'b1;
		@(negedge clock_in);
		start_id = 1'b0;
		push(w[0]);
		push(w[1]);
		wait_done(90000);
		check(16'({pass, fail}), 16'h0002);
		check(fail_addr, 16'h0000);
		check(16'({vcc, vpp}), 16'h0000);
		check(id_word, 16'h0000);
		check(model_u.first_addr, FIRST_ADDR);
		check(16'(model_u.pulses[0]), 16'h0002);
		check(16'(model_u.pulses[1]), 16'h0001);
		check(model_u.mem[0], w[0]);
		check(model_u.mem[1], w[1]);
	endtask
	task automatic t_id(input logic sel, input logic [15:0] exp);
		@(negedge clock_in);
		start_id = 1'b1;
		id_sel = sel;
		@(negedge clock_in);
		start_id = 1'b0;
		wait_done(2000);
		check(id_word, exp);
	endtask
	// ==========================================
	// Clock, watchdog and main sequence
	initial begin
		clock_in = 1'b0;
		forever #2.5 clock_in = ~clock_in;
	end
	initial begin
		// Expected run is about 70000 cycles
		#450000;
		n_fail++;
		test_done();
	end
	initial begin
		{n_fail, num_checks} = '0;
		{start_prog, start_id, id_sel, src_valid} = 4'h0;
		{src_data, last_addr} = 32'h0000_0000;
		w[0] = 16'ha5c3;
		w[1] = 16'h0f0f;
		rst_b_in = 1'b0;
		repeat (3) @(posedge clock_in);
		@(negedge clock_in);
		rst_b_in = 1'b1;
		t_prog();
		t_id(1'b0, MAKER_WORD);
		t_id(1'b1, DEVICE_WORD);
		check(16'(model_u.n_err), 16'h0000);
		test_done();
	end
endmodule // testbench
`default_nettype wire
